// ### dosc_pkg.sv
// Shared constants and types of the dual oscillator clock and mode controller.
// Assumes a 10 MHz system clock that stands in for the fast oscillator clock.
package dosc_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [3:0] ADDR_SYSCTL2 = 4'h0; // system_control_two
    localparam logic [3:0] ADDR_TBCTL = 4'h1; // timebase_control
    localparam logic [3:0] ADDR_STATUS = 4'h2; // Mode and timing status, read only

    // Field positions in system_control_two
    localparam int FAST_EN_BIT = 7; // fast_osc_enable
    localparam int SLOW_EN_BIT = 6; // slow_osc_enable
    localparam int CORE_SEL_BIT = 5; // core_clock_select
    localparam int HALT_BIT = 4; // core_halt_request, reads zero
    localparam int TG_HALT_BIT = 2; // timing_generator_halt, reads zero

    // Field positions in timebase_control
    localparam int DV7_BIT = 7; // divider_stage7_source
    localparam int TB_EN_BIT = 3; // timebase_timer_enable
    localparam int TB_SEL_LSB = 0; // timebase_source_select, three bits

    // Field positions in the status register
    localparam int ST_MODE_LSB = 0;
    localparam int ST_STATE_LSB = 4;
    localparam int ST_PEND_BIT = 7;

    // Timing generator geometry
    localparam int PRE_W = 2; // Two prescaler stages
    localparam int DIVLO_W = 6; // Divider stages one to six
    localparam int DIVHI_W = 15; // Divider stages seven to twenty-one
    localparam logic [1:0] LAST_STATE = 2'h3; // Four states per machine cycle
    localparam logic [3:0] INSTR_MAX = 4'hA; // Longest instruction in machine cycles
    localparam logic [3:0] INSTR_MIN = 4'h1;

    // Operating modes, Gray coded along the usual paths
    typedef enum logic [2:0] {
        MODE_FSR = 3'h0, // fast_single_run
        MODE_FSH = 3'h1, // fast_single_halt
        MODE_FDR = 3'h2, // fast_dual_run
        MODE_FDH = 3'h3, // fast_dual_halt
        MODE_TBH = 3'h4, // timebase_only_halt
        MODE_SDR = 3'h6, // slow_dual_run
        MODE_SOR = 3'h7 // slow_only_run
    } dosc_mode_e;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } dosc_bus_s;

    // Clock enables handed to the core and peripherals
    typedef struct packed {
        logic mainEn; // One main system clock period
        logic cpuEn;
        logic wdtEn;
        logic perEn;
        logic tbClkEn;
        logic cycEnd; // Last state of a machine cycle
        logic [1:0] stateNum;
    } dosc_clk_s;

    // Whole state of the controller
    typedef struct packed {
        dosc_mode_e mode;
        logic [PRE_W-1:0] pre;
        logic [DIVLO_W-1:0] divLo;
        logic [DIVHI_W-1:0] divHi;
        logic [3:0] instrCnt;
        logic [2:0] slowSync;
        logic stopPrev;
        logic tbPrev;
        logic fastOscEn;
        logic slowOscEn;
        logic coreClkSel;
        logic dv7Src;
        logic tbTimerEn;
        logic [2:0] tbSel;
        logic tbEnAtEntry;
        logic tbPend;
        logic tbService;
        dosc_clk_s clk;
        logic instrEnd;
        logic wakeSvc;
        logic wakeCont;
        logic [DATA_W-1:0] rdata;
    } dosc_state_s;

    // Reset: fast single run, fast oscillator on
    localparam dosc_state_s ST_RESET = '{mode: MODE_FSR, fastOscEn: 1'b1, default: '0};

endpackage : dosc_pkg

// ### dosc_clock_ctrl.sv
// Dual oscillator clock and operating mode controller: timing generator and mode FSM.
// Assumes clk_sys is the fast clock, the slow clock arrives on a pin, and the
// stop controller, interrupt controller and core sit on clk_sys.
`timescale 1ns/1ns
module dosc_clock_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire dosc_pkg::dosc_bus_s bus,
    output logic [dosc_pkg::DATA_W-1:0] rdData,
    input wire logic slowOscIn,
    input wire logic intReq,
    input wire logic globalIntEnable,
    input wire logic timebaseIntEnable,
    input wire logic timebaseIrqAck,
    input wire logic stopActive,
    input wire logic stopWarmup,
    input wire logic stopFromFast,
    input wire logic [3:0] instrCycles,
    output dosc_pkg::dosc_clk_s clkOut,
    output logic timebaseIrqPend,
    output logic timebaseIrqService,
    output logic wakeToService,
    output logic wakeToContinue,
    output logic instrEnd,
    output logic fastOscRun,
    output logic slowOscRun,
    output logic slowPinsGpio,
    output dosc_pkg::dosc_mode_e modeOut
);

    // Reset release synchroniser
    logic [1:0] rstSync_r;
    logic rstN;

    // Registered state and its next value
    dosc_pkg::dosc_state_s st_r;
    dosc_pkg::dosc_state_s st_nxt;

    // Decoded helpers
    logic slowMode; // Main clock taken from the slow oscillator
    logic slowEdge; // Rising edge of the synchronised slow clock
    logic stopEdge; // Stop mode entered or released
    logic mainTick; // One main system clock period elapses
    logic cycEndNow; // Machine cycle ends in this period
    logic cpuRun; // Mode lets the core execute
    logic lowIn; // Input to divider stage one
    logic lowCarry; // Output of divider stage six
    logic hiIn; // Input to divider stage seven
    logic tbBit; // Selected time base source
    logic tbFall;
    logic wrSys;
    logic wrTb;
    logic haltReq;
    logic tgReq;
    logic [3:0] instrLen;
    logic [3:0] instrCntInc;

    // Reset is asserted at once and released two edges later
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rstSync_r <= 2'h0;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstN = rstSync_r[1];

    // Slow modes take the main clock from the slow oscillator
    // Slow enable is assumed to stay on here, software keeps it so
    assign slowMode = (st_r.mode == dosc_pkg::MODE_SDR) || (st_r.mode == dosc_pkg::MODE_SOR);
    // Only the second and third sync stages are looked at
    assign slowEdge = st_r.slowSync[1] && !st_r.slowSync[2] && st_r.slowOscEn;
    assign stopEdge = stopActive != st_r.stopPrev;
    // One state per fast period or per slow period; none while stopped
    assign mainTick = !stopActive && !stopWarmup && (slowMode ? slowEdge : 1'b1);
    assign cycEndNow = mainTick && (st_r.clk.stateNum == dosc_pkg::LAST_STATE);

    // Stage one input stops in slow modes, so stages one to six stand
    assign lowIn = !stopActive && !slowMode && (st_r.pre == 2'h3);
    assign lowCarry = lowIn && (&st_r.divLo);

    // Stage seven source; a set source bit is only safe with a stable slow clock
    assign hiIn = (stopWarmup && stopFromFast) ? lowCarry :
                  (slowMode || st_r.dv7Src) ? slowEdge : lowCarry;

    // Modes in which the core executes
    assign cpuRun = st_r.mode inside {dosc_pkg::MODE_FSR, dosc_pkg::MODE_FDR,
                                      dosc_pkg::MODE_SDR, dosc_pkg::MODE_SOR};

    // Time base source is one of stages seven to fourteen
    assign tbBit = st_r.divHi[st_r.tbSel];
    assign tbFall = st_r.tbPrev && !tbBit;

    // Register write decode
    assign wrSys = bus.wr && (bus.addr == dosc_pkg::ADDR_SYSCTL2);
    assign wrTb = bus.wr && (bus.addr == dosc_pkg::ADDR_TBCTL);
    assign haltReq = wrSys && bus.wdata[dosc_pkg::HALT_BIT];
    assign tgReq = wrSys && bus.wdata[dosc_pkg::TG_HALT_BIT];

    // Instruction length clamped into the ten legal classes
    assign instrLen = (instrCycles < dosc_pkg::INSTR_MIN) ? dosc_pkg::INSTR_MIN :
                      (instrCycles > dosc_pkg::INSTR_MAX) ? dosc_pkg::INSTR_MAX : instrCycles;
    assign instrCntInc = 4'(st_r.instrCnt + 4'h1);

    // Next state of the whole controller
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.slowSync = {st_r.slowSync[1:0], slowOscIn};
        st_nxt.stopPrev = stopActive;
        st_nxt.tbPrev = tbBit;
        st_nxt.instrEnd = 1'b0;
        st_nxt.wakeSvc = 1'b0;
        st_nxt.wakeCont = 1'b0;

        // Prescaler and divider count, cleared on any stop edge
        if (stopEdge)
        begin
            st_nxt.pre = '0;
            st_nxt.divLo = '0;
            st_nxt.divHi = '0;
        end
        else
        begin
            if (!stopActive && !slowMode)
                st_nxt.pre = 2'(st_r.pre + 2'h1);
            if (lowIn)
                st_nxt.divLo = 6'(st_r.divLo + 6'h1);
            if (hiIn)
                st_nxt.divHi = 15'(st_r.divHi + 15'h1);
        end

        // Machine cycle states S0 to S3
        if (mainTick)
            st_nxt.clk.stateNum = 2'(st_r.clk.stateNum + 2'h1);

        // Count machine cycles of the running instruction
        if (cycEndNow && cpuRun) // Registered enable lags a slow tick, so use the mode
        begin
            if (instrCntInc >= instrLen)
            begin
                st_nxt.instrCnt = 4'h0;
                st_nxt.instrEnd = 1'b1;
            end
            else
                st_nxt.instrCnt = instrCntInc;
        end

        // Software control bits
        if (wrSys)
        begin
            st_nxt.fastOscEn = bus.wdata[dosc_pkg::FAST_EN_BIT];
            st_nxt.slowOscEn = bus.wdata[dosc_pkg::SLOW_EN_BIT];
            st_nxt.coreClkSel = bus.wdata[dosc_pkg::CORE_SEL_BIT];
        end
        if (wrTb)
        begin
            st_nxt.dv7Src = bus.wdata[dosc_pkg::DV7_BIT];
            st_nxt.tbTimerEn = bus.wdata[dosc_pkg::TB_EN_BIT];
            st_nxt.tbSel = bus.wdata[dosc_pkg::TB_SEL_LSB +: 3];
        end

        // Time base latch: acknowledge clears, a new set wins
        if (timebaseIrqAck)
            st_nxt.tbPend = 1'b0;

        // Operating mode transitions
        unique case (st_r.mode)
            dosc_pkg::MODE_FSR:
            begin
                if (tgReq)
                begin
                    st_nxt.mode = dosc_pkg::MODE_TBH;
                    st_nxt.tbEnAtEntry = st_r.tbTimerEn;
                end
                else if (haltReq)
                begin
                    st_nxt.mode = dosc_pkg::MODE_FSH;
                end
                else if (st_r.slowOscEn)
                begin
                    st_nxt.mode = dosc_pkg::MODE_FDR;
                end
            end
            dosc_pkg::MODE_FSH, dosc_pkg::MODE_FDH:
            begin
                // Either halt wakes on any interrupt request
                if (intReq)
                begin
                    st_nxt.mode = (st_r.mode == dosc_pkg::MODE_FSH) ?
                                  dosc_pkg::MODE_FSR : dosc_pkg::MODE_FDR;
                    st_nxt.wakeSvc = globalIntEnable;
                    st_nxt.wakeCont = !globalIntEnable;
                end
            end
            dosc_pkg::MODE_TBH:
            begin
                // Falling edge of the time base source ends the halt
                if (tbFall)
                begin
                    st_nxt.mode = dosc_pkg::MODE_FSR;
                    if (st_r.tbEnAtEntry)
                    begin
                        st_nxt.tbPend = 1'b1;
                    end
                end
            end
            dosc_pkg::MODE_FDR:
            begin
                if (haltReq)
                begin
                    st_nxt.mode = dosc_pkg::MODE_FDH;
                end
                else if (!st_r.slowOscEn)
                begin
                    st_nxt.mode = dosc_pkg::MODE_FSR;
                end
                else if (st_r.coreClkSel && cycEndNow)
                begin
                    st_nxt.mode = dosc_pkg::MODE_SDR;
                end
            end
            dosc_pkg::MODE_SDR:
            begin
                // Source changes wait for the end of a machine cycle
                if (!st_r.coreClkSel && cycEndNow)
                begin
                    st_nxt.mode = dosc_pkg::MODE_FDR;
                end
                else if (!st_r.fastOscEn && cycEndNow)
                begin
                    st_nxt.mode = dosc_pkg::MODE_SOR;
                end
            end
            dosc_pkg::MODE_SOR:
            begin
                if (st_r.fastOscEn && cycEndNow)
                begin
                    st_nxt.mode = dosc_pkg::MODE_SDR;
                end
            end
            default:
            begin
                st_nxt.mode = dosc_pkg::MODE_FSR;
            end
        endcase

        // Interrupt taken only with all three enables set
        st_nxt.tbService = st_r.tbPend && globalIntEnable && timebaseIntEnable && st_r.tbTimerEn;

        // Clock enables; halts keep peripherals, generator halt keeps time base only
        st_nxt.clk.mainEn = mainTick;
        st_nxt.clk.cycEnd = cycEndNow;
        st_nxt.clk.cpuEn = mainTick && cpuRun;
        st_nxt.clk.wdtEn = st_nxt.clk.cpuEn;
        st_nxt.clk.perEn = mainTick && (st_r.mode != dosc_pkg::MODE_TBH);
        st_nxt.clk.tbClkEn = mainTick;

        // Read data stand one cycle after the strobe; unmapped reads zero
        st_nxt.rdata = '0;
        if (bus.rd)
        begin
            unique case (bus.addr)
                dosc_pkg::ADDR_SYSCTL2:
                begin
                    st_nxt.rdata[dosc_pkg::FAST_EN_BIT] = st_r.fastOscEn;
                    st_nxt.rdata[dosc_pkg::SLOW_EN_BIT] = st_r.slowOscEn;
                    st_nxt.rdata[dosc_pkg::CORE_SEL_BIT] = st_r.coreClkSel;
                end
                dosc_pkg::ADDR_TBCTL:
                begin
                    st_nxt.rdata[dosc_pkg::DV7_BIT] = st_r.dv7Src;
                    st_nxt.rdata[dosc_pkg::TB_EN_BIT] = st_r.tbTimerEn;
                    st_nxt.rdata[dosc_pkg::TB_SEL_LSB +: 3] = st_r.tbSel;
                end
                dosc_pkg::ADDR_STATUS:
                begin
                    st_nxt.rdata[dosc_pkg::ST_MODE_LSB +: 3] = st_r.mode;
                    st_nxt.rdata[dosc_pkg::ST_STATE_LSB +: 2] = st_r.clk.stateNum;
                    st_nxt.rdata[dosc_pkg::ST_PEND_BIT] = st_r.tbPend;
                end
                default:
                begin
                    st_nxt.rdata = '0;
                end
            endcase
        end
    end

    // State register; reset lands in fast single run
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            st_r <= dosc_pkg::ST_RESET;
        else
            st_r <= st_nxt;
    end

    // Outputs straight from the state register
    assign rdData = st_r.rdata;
    assign clkOut = st_r.clk;
    assign timebaseIrqPend = st_r.tbPend;
    assign timebaseIrqService = st_r.tbService;
    assign wakeToService = st_r.wakeSvc;
    assign wakeToContinue = st_r.wakeCont;
    assign instrEnd = st_r.instrEnd;
    assign modeOut = st_r.mode;
    // Fast oscillator follows the mode; slow oscillator and slow pin function follow the slow enable bit
    assign fastOscRun = (st_r.mode != dosc_pkg::MODE_SOR);
    assign slowOscRun = st_r.slowOscEn;
    assign slowPinsGpio = !st_r.slowOscEn;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstN);

    sequence haltWakeSeq;
        (st_r.mode == dosc_pkg::MODE_FSH) && intReq;
    endsequence

    sequence tbResumeSeq;
        (st_r.mode == dosc_pkg::MODE_TBH) && tbFall;
    endsequence

    chk_halt_entry: assert property ((st_r.mode == dosc_pkg::MODE_FSR) && haltReq && !tgReq
        |=> st_r.mode == dosc_pkg::MODE_FSH) else $error("halt request not taken");
    chk_halt_clocks: assert property ((st_r.mode == dosc_pkg::MODE_FSH) && !stopActive
        && !stopWarmup |=> !clkOut.cpuEn && !clkOut.wdtEn && clkOut.perEn)
        else $error("halt clock gating wrong");
    chk_irq_wake: assert property (haltWakeSeq |=> (st_r.mode == dosc_pkg::MODE_FSR)
        && (wakeToService == $past(globalIntEnable))) else $error("halt wake wrong");
    chk_tg_gating: assert property (st_r.mode == dosc_pkg::MODE_TBH
        |=> !clkOut.perEn && !clkOut.cpuEn) else $error("peripherals clocked in halt");
    chk_tb_resume: assert property (tbResumeSeq |=> (st_r.mode == dosc_pkg::MODE_FSR)
        && (timebaseIrqPend || !$past(st_r.tbEnAtEntry))) else $error("time base exit");
    chk_cycle_states: assert property (clkOut.cycEnd |-> (clkOut.stateNum == 2'h0)
        && ($past(clkOut.stateNum) == 2'h3)) else $error("machine cycle not four states");
    chk_div_clear: assert property (stopEdge |=> (st_r.pre == '0) && (st_r.divLo == '0)
        && (st_r.divHi == '0)) else $error("divider not cleared");
    chk_slow_lowstop: assert property (slowMode && !stopEdge |=> $stable(st_r.divLo))
        else $error("low divider runs in slow mode");
    chk_slow_stage7: assert property (slowMode && !slowEdge && !stopEdge
        && !(stopWarmup && stopFromFast) |=> $stable(st_r.divHi))
        else $error("stage seven not on slow clock");
    chk_switch_bound: assert property ((st_r.mode == dosc_pkg::MODE_FDR)
        ##1 (st_r.mode == dosc_pkg::MODE_SDR) |-> $past(cycEndNow))
        else $error("source switched mid cycle");

endmodule : dosc_clock_ctrl

// ### dosc_core_model.sv
// Model of the core and peripherals that sit behind the clock controller.
// Assumes clk_sys is the fast clock; makes the free running slow oscillator pin.
`timescale 1ns/1ns
module dosc_core_model #(
    parameter int SLOW_HALF = 4 // Fast cycles per slow half period, kept short on purpose
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clear,
    input wire dosc_pkg::dosc_clk_s clkIn,
    input wire logic instrEnd,
    output logic slowOscIn,
    output int mainCnt,
    output int cycCnt,
    output int cpuCnt,
    output int perCnt,
    output int instrCnt
);
    int half; // Slow half period count

    // Crystal runs free, so reset does not stop it
    initial
    begin
        slowOscIn = 1'b0;
        half = 0;
    end
    always @(posedge clk_sys)
    begin
        half <= (half == SLOW_HALF - 1) ? 0 : half + 1;
        if (half == SLOW_HALF - 1)
            slowOscIn <= ~slowOscIn;
    end

    // Tally of clock enables seen by the consumers
    always @(posedge clk_sys)
    begin
        if (!rst_n || clear)
        begin
            mainCnt <= 0;
            cycCnt <= 0;
            cpuCnt <= 0;
            perCnt <= 0;
            instrCnt <= 0;
        end
        else
        begin
            mainCnt <= mainCnt + int'(clkIn.mainEn);
            cycCnt <= cycCnt + int'(clkIn.cycEnd);
            cpuCnt <= cpuCnt + int'(clkIn.cpuEn);
            perCnt <= perCnt + int'(clkIn.perEn);
            instrCnt <= instrCnt + int'(instrEnd);
        end
    end
endmodule : dosc_core_model

// ### dosc_clock_ctrl_test.sv
// Self-checking bench of the clock and mode controller.
// Assumes the core model above; the stop inputs are driven by one scenario.
`timescale 1ns/1ns
module dosc_clock_ctrl_test;
    typedef struct {
        logic [7:0] wdata; // Value written to system_control_two
        dosc_pkg::dosc_mode_e mode; // Mode it should lead to
        logic fastRun;
        logic gpio;
    } dosc_row_s;
    logic clk_sys, rst_n, intReq, gie, tbIe, tbAck, clear, slowOscIn;
    logic wakeSvc, wakeCont, instrEnd, fastOscRun, slowOscRun, slowPinsGpio;
    logic tbPend, tbSvc, svcSeen, contSeen, stopAct, stopWarm, stopFast;
    logic [7:0] rdData, rv;
    logic [3:0] instrCycles;
    dosc_pkg::dosc_bus_s bus;
    dosc_pkg::dosc_clk_s clkOut;
    dosc_pkg::dosc_mode_e modeOut;
    int mainCnt, cycCnt, cpuCnt, perCnt, instrCnt, errCount, nCompared, cycles;
    dosc_row_s rows[6];

    dosc_clock_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdData(rdData),
        .slowOscIn(slowOscIn), .intReq(intReq), .globalIntEnable(gie),
        .timebaseIntEnable(tbIe), .timebaseIrqAck(tbAck), .stopActive(stopAct),
        .stopWarmup(stopWarm), .stopFromFast(stopFast), .instrCycles(instrCycles),
        .clkOut(clkOut), .timebaseIrqPend(tbPend), .timebaseIrqService(tbSvc),
        .wakeToService(wakeSvc), .wakeToContinue(wakeCont), .instrEnd(instrEnd),
        .fastOscRun(fastOscRun), .slowOscRun(slowOscRun), .slowPinsGpio(slowPinsGpio),
        .modeOut(modeOut));
    dosc_core_model i_core (.clk_sys(clk_sys), .rst_n(rst_n), .clear(clear),
        .clkIn(clkOut), .instrEnd(instrEnd), .slowOscIn(slowOscIn), .mainCnt(mainCnt),
        .cycCnt(cycCnt), .cpuCnt(cpuCnt), .perCnt(perCnt), .instrCnt(instrCnt));

    // Clock at 10 MHz
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Compare and count
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic conclude();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // One write cycle; a gap edge follows since the strobe drops on the next edge
    task automatic wrReg(logic [3:0] a, logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask : wrReg

    // Read data stands only in the cycle after the strobe
    task automatic rdReg(logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 d = rdData;
    endtask : rdReg

    // Bounded wait for a mode, noting wake pulses on the way
    task automatic waitMode(dosc_pkg::dosc_mode_e m, int lim);
        int n;
        n = 0;
        while (modeOut !== m && n < lim)
        begin
            @(posedge clk_sys);
            #1 n++;
            svcSeen |= wakeSvc;
            contSeen |= wakeCont;
        end
        check("mode", 8'(modeOut), 8'(m));
    endtask : waitMode

    // Hang guard, ample for the whole sequence
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            errCount++;
            conclude();
        end
    end

    initial
    begin
        {rst_n, intReq, gie, tbIe, tbAck, clear, svcSeen, contSeen} = '0;
        {stopAct, stopWarm, stopFast} = '0;
        bus = '0;
        instrCycles = 4'h3;
        {errCount, nCompared, cycles} = '0;
        // Slow oscillator is turned on before any dual mode is used
        rows = '{'{8'hC0, dosc_pkg::MODE_FDR, 1'b1, 1'b0}, '{8'hE0, dosc_pkg::MODE_SDR, 1'b1, 1'b0},
            '{8'h60, dosc_pkg::MODE_SOR, 1'b0, 1'b0}, '{8'hE0, dosc_pkg::MODE_SDR, 1'b1, 1'b0},
            '{8'hC0, dosc_pkg::MODE_FDR, 1'b1, 1'b0}, '{8'h80, dosc_pkg::MODE_FSR, 1'b1, 1'b1}};
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 check("reset mode", 8'(modeOut), 8'(dosc_pkg::MODE_FSR));
        check("reset gpio", 8'(slowPinsGpio), 8'h01);
        rdReg(dosc_pkg::ADDR_SYSCTL2, rv);
        check("reset ctl", rv, 8'h80);
        rdReg(4'hF, rv);
        check("unmapped", rv, 8'h00);
        $display("test reset done");
        // Machine cycle of four states, instruction of three cycles
        wait (clkOut.cycEnd === 1'b1);
        @(posedge clk_sys);
        clear <= 1'b1;
        @(posedge clk_sys);
        clear <= 1'b0;
        repeat (120) @(posedge clk_sys);
        #1 check("states", 8'(mainCnt - 4 * cycCnt < 4 && cycCnt > 0), 8'h01);
        check("instr", 8'(cycCnt - 3 * instrCnt < 6 && instrCnt > 0), 8'h01);
        $display("test cycle done");
        // Table of mode changes through the dual modes
        foreach (rows[i])
        begin
            wrReg(dosc_pkg::ADDR_SYSCTL2, rows[i].wdata);
            waitMode(rows[i].mode, 300);
            check("fast run", 8'(fastOscRun), 8'(rows[i].fastRun));
            check("slow run", 8'(slowOscRun), 8'(!rows[i].gpio));
            check("gpio", 8'(slowPinsGpio), 8'(rows[i].gpio));
            rdReg(dosc_pkg::ADDR_SYSCTL2, rv);
            check("ctl read", rv, rows[i].wdata & 8'hE0);
        end
        $display("test modes done");
        // Halt in single and dual mode, woken with and without service
        for (int i = 0; i < 2; i++)
        begin
            gie <= (i == 0);
            wrReg(dosc_pkg::ADDR_SYSCTL2, i ? 8'hC0 : 8'h80);
            waitMode(i ? dosc_pkg::MODE_FDR : dosc_pkg::MODE_FSR, 300);
            wrReg(dosc_pkg::ADDR_SYSCTL2, i ? 8'hD0 : 8'h90);
            waitMode(i ? dosc_pkg::MODE_FDH : dosc_pkg::MODE_FSH, 4);
            clear <= 1'b1;
            @(posedge clk_sys);
            clear <= 1'b0;
            repeat (20) @(posedge clk_sys);
            #1 check("cpu halted", 8'(cpuCnt), 8'h00);
            check("per runs", 8'(perCnt > 0), 8'h01);
            check("wdt halted", 8'(clkOut.wdtEn), 8'h00);
            {svcSeen, contSeen} = '0;
            intReq <= 1'b1;
            waitMode(i ? dosc_pkg::MODE_FDR : dosc_pkg::MODE_FSR, 5);
            intReq <= 1'b0;
            repeat (2) @(posedge clk_sys);
            #1 check("wake kind", {6'h00, svcSeen, contSeen}, i ? 8'h01 : 8'h02);
        end
        $display("test halt done");
        // Stop, then warm-up after a fast stop: no main clock, divider cleared at both edges
        stopAct <= 1'b1;
        stopFast <= 1'b1;
        clear <= 1'b1;
        @(posedge clk_sys);
        clear <= 1'b0;
        repeat (10) @(posedge clk_sys);
        stopAct <= 1'b0;
        stopWarm <= 1'b1;
        repeat (300) @(posedge clk_sys);
        #1 check("stop hold", 8'(mainCnt), 8'h00);
        stopWarm <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 check("stop resume", 8'(mainCnt > 0), 8'h01);
        $display("test stop done");
        // Time base only halt, latch set at return; all three enables on for service
        tbIe <= 1'b1;
        gie <= 1'b1;
        wrReg(dosc_pkg::ADDR_SYSCTL2, 8'h80);
        wrReg(dosc_pkg::ADDR_TBCTL, 8'h08); // Stage seven source stays zero
        wrReg(dosc_pkg::ADDR_SYSCTL2, 8'h84);
        waitMode(dosc_pkg::MODE_TBH, 4);
        clear <= 1'b1;
        @(posedge clk_sys);
        clear <= 1'b0;
        #1 check("tb clock", 8'(clkOut.tbClkEn), 8'h01);
        waitMode(dosc_pkg::MODE_FSR, 1000);
        check("per gated", 8'(perCnt == 0 && cpuCnt == 0), 8'h01);
        check("tb latch", 8'(tbPend), 8'h01);
        repeat (2) @(posedge clk_sys);
        #1 check("tb service", 8'(tbSvc), 8'h01);
        tbAck <= 1'b1;
        @(posedge clk_sys);
        tbAck <= 1'b0;
        @(posedge clk_sys);
        #1 check("tb ack", 8'(tbPend), 8'h00);
        $display("test timebase done");
        conclude();
    end
endmodule : dosc_clock_ctrl_test
